// ### rtl/sensor_ui_regs.svh
// Purpose: offsets, field positions, limits of the sensor status bank
// Assumes: byte-wide register port, 8-bit addresses
// Notes: included by the bank module only
`ifndef SENSOR_UI_REGS_SVH
`define SENSOR_UI_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_GLOBAL_EVENTS 8'h11
`define ADDR_CHAN_FLAGS    8'h12
`define ADDR_BODY_HYS_FLAGS 8'h13
`define ADDR_HYS_RES_LO    8'h14
`define ADDR_HYS_RES_HI    8'h15
`define ADDR_MAG_FLAGS     8'h16
`define ADDR_MAG_RES_LO    8'h17
`define ADDR_MAG_RES_HI    8'h18
`define ADDR_TEMP_FLAGS    8'h19
`define ADDR_TEMP_RES_LO   8'h1a
`define ADDR_TEMP_RES_HI   8'h1b

// ----------------------------------------
// field positions
// ----------------------------------------
`define EV_CAP_BIT     0
`define EV_BODY_BIT    1
`define EV_MAG_BIT     2
`define EV_HYS_BIT     4
`define CH_TOUCH_LSB   4
`define CH_PROX_LSB    0
`define BODY_STANDOFF_BIT 4
`define BODY_QREL_BIT  2
`define BODY_MOVE_BIT  1
`define BODY_HALT_BIT  0
`define HYS_SIGN_BIT   7
`define HYS_TOUCH_BIT  6
`define HYS_PROX_BIT   5
`define MAG_TOUCH_BIT  2
`define MAG_PROX_BIT   1
`define MAG_POL_BIT    0
`define TEMP_TRIP_BIT  7

// ----------------------------------------
// values
// ----------------------------------------
`define RESET_BYTE        8'h00
`define RESET_WORD        16'h0000
`define MAG_RESULT_MAX    16'h1f40
`define TEMP_OFFSET_EARLY 16'h0064
`define TEMP_OFFSET_LATE  16'h0028

`endif

// ### rtl/sensor_ui_pkg.sv
// Purpose: state type of the sensor status bank
// Assumes: nothing
// Notes: constants live in sensor_ui_regs.svh
package sensor_ui_pkg;

	typedef struct packed {
		logic [2:0]  ch_touch;
		logic [2:0]  ch_prox;
		logic        standoff;
		logic        quick_rel;
		logic        movement;
		logic        filt_halt;
		logic        hys_mode;
		logic        hys_sign;
		logic        hys_touch;
		logic        hys_prox;
		logic [15:0] hys_result;
		logic        mag_touch;
		logic        mag_prox;
		logic        mag_pol;
		logic [15:0] mag_result;
		logic        temp_trip;
		logic [15:0] temp_result;
		logic        ev_cap;
		logic        ev_body;
		logic        ev_mag;
		logic        ev_hys;
		logic [7:0]  rdata;
		logic        rvalid;
		logic        wr_ignored;
	} bank_state_t;

endpackage

// ### rtl/sensor_ui_status_registers.sv
// Purpose: read-only event flag and result bank of a proximity sensor
// Assumes: engine inputs and register port share CLK; UPD is a one-cycle pulse
// Notes: writes are acknowledged and discarded
//
// Summary of operation
// - global event bits 2,1,0 flag pending service
// - bits 6..4 are channel 2..0 touch
// - bits 2..0 are channel 2..0 proximity
// - body flags: standoff, quick release, movement, halt
// - hysteresis bit 7 is delta direction sign
// - hysteresis bits 6,5 are touch and proximity
// - hysteresis result word, low byte first
// - magnetic bits 2,1 are touch and proximity
// - magnetic bit 0: north 0, south 1
// - flip-chip build parameter inverts the polarity bit
// - magnetic result word, little endian, up to 8000
// - temperature flag bit 7 marks a trip
// - temperature result word, low byte first
// - calibrated build adds revision offset, 100 or 40
// - global event bit 4 flags hysteresis events
`timescale 1ns/100ps
`include "sensor_ui_regs.svh"

module sensor_ui_status_registers #(
	parameter logic        FLIP_CHIP   = 1'b0,
	parameter logic        CALIBRATED  = 1'b0,
	parameter logic [15:0] TEMP_OFFSET = `TEMP_OFFSET_EARLY
) (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	input  wire logic        UPD,
	input  wire logic [2:0]  CH_TOUCH,
	input  wire logic [2:0]  CH_PROX,
	input  wire logic        STANDOFF,
	input  wire logic        QUICK_REL,
	input  wire logic        MOVEMENT,
	input  wire logic        FILT_HALT,
	input  wire logic        HYS_MODE,
	input  wire logic        HYS_SIGN,
	input  wire logic        HYS_TOUCH,
	input  wire logic        HYS_PROX,
	input  wire logic [15:0] HYS_RESULT,
	input  wire logic        MAG_TOUCH,
	input  wire logic        MAG_PROX,
	input  wire logic        MAG_SOUTH,
	input  wire logic [15:0] MAG_RESULT,
	input  wire logic        TEMP_TRIP,
	input  wire logic [15:0] TEMP_RAW,
	input  wire logic [7:0]  ADDR,
	input  wire logic        RD,
	input  wire logic        WR,
	output logic [7:0]       RDATA,
	output logic             RVALID,
	output logic             WR_IGNORED
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	sensor_ui_pkg::bank_state_t st_ff;
	sensor_ui_pkg::bank_state_t nxt_st;

	logic [7:0]  chan_byte;
	logic [7:0]  body_byte;
	logic [7:0]  hys_byte;
	logic [7:0]  mag_byte;
	logic [7:0]  temp_byte;
	logic [7:0]  event_byte;
	logic [7:0]  read_mux;
	logic        mag_pol_in;
	logic [15:0] mag_clamped;
	logic [15:0] temp_value;
	logic        ev_rd_clear;

	// ----------------------------------------
	// register images
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_chan
			assign chan_byte[`CH_TOUCH_LSB + gi] = st_ff.ch_touch[gi];
			assign chan_byte[`CH_PROX_LSB + gi]  = st_ff.ch_prox[gi];
		end
	endgenerate
	assign chan_byte[7] = 1'b0;
	assign chan_byte[3] = 1'b0;

	always_comb begin
		body_byte = `RESET_BYTE;
		body_byte[`BODY_STANDOFF_BIT] = st_ff.standoff;
		body_byte[`BODY_QREL_BIT]     = st_ff.quick_rel;
		body_byte[`BODY_MOVE_BIT]     = st_ff.movement;
		body_byte[`BODY_HALT_BIT]     = st_ff.filt_halt;
		hys_byte = `RESET_BYTE;
		hys_byte[`HYS_SIGN_BIT]  = st_ff.hys_sign;
		hys_byte[`HYS_TOUCH_BIT] = st_ff.hys_touch;
		hys_byte[`HYS_PROX_BIT]  = st_ff.hys_prox;
		mag_byte = `RESET_BYTE;
		mag_byte[`MAG_TOUCH_BIT] = st_ff.mag_touch;
		mag_byte[`MAG_PROX_BIT]  = st_ff.mag_prox;
		mag_byte[`MAG_POL_BIT]   = st_ff.mag_pol;
		temp_byte = `RESET_BYTE;
		temp_byte[`TEMP_TRIP_BIT] = st_ff.temp_trip;
		event_byte = `RESET_BYTE;
		event_byte[`EV_CAP_BIT]  = st_ff.ev_cap;
		event_byte[`EV_BODY_BIT] = st_ff.ev_body;
		event_byte[`EV_MAG_BIT]  = st_ff.ev_mag;
		event_byte[`EV_HYS_BIT]  = st_ff.ev_hys;
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	always_comb begin
		case (ADDR)
			`ADDR_GLOBAL_EVENTS:  read_mux = event_byte;
			`ADDR_CHAN_FLAGS:     read_mux = chan_byte;
			`ADDR_BODY_HYS_FLAGS: read_mux = st_ff.hys_mode ? hys_byte : body_byte;
			`ADDR_HYS_RES_LO:     read_mux = st_ff.hys_result[7:0];
			`ADDR_HYS_RES_HI:     read_mux = st_ff.hys_result[15:8];
			`ADDR_MAG_FLAGS:      read_mux = mag_byte;
			`ADDR_MAG_RES_LO:     read_mux = st_ff.mag_result[7:0];
			`ADDR_MAG_RES_HI:     read_mux = st_ff.mag_result[15:8];
			`ADDR_TEMP_FLAGS:     read_mux = temp_byte;
			`ADDR_TEMP_RES_LO:    read_mux = st_ff.temp_result[7:0];
			`ADDR_TEMP_RES_HI:    read_mux = st_ff.temp_result[15:8];
			default:              read_mux = `RESET_BYTE;
		endcase
	end

	// ----------------------------------------
	// engine input conditioning
	// ----------------------------------------
	assign mag_pol_in  = MAG_SOUTH ^ FLIP_CHIP;
	assign mag_clamped = (MAG_RESULT > `MAG_RESULT_MAX) ? `MAG_RESULT_MAX : MAG_RESULT;
	assign temp_value  = CALIBRATED ? 16'(TEMP_RAW + TEMP_OFFSET) : TEMP_RAW;
	assign ev_rd_clear = RD && (ADDR == `ADDR_GLOBAL_EVENTS);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rvalid     = 1'b0;
		nxt_st.wr_ignored = 1'b0;
		if (ev_rd_clear) begin
			nxt_st.ev_cap  = 1'b0;
			nxt_st.ev_body = 1'b0;
			nxt_st.ev_mag  = 1'b0;
			nxt_st.ev_hys  = 1'b0;
		end
		if (RD) begin
			nxt_st.rdata  = read_mux;
			nxt_st.rvalid = 1'b1;
		end
		if (WR) begin
			nxt_st.wr_ignored = 1'b1;
		end
		if (UPD) begin
			nxt_st.ch_touch    = CH_TOUCH;
			nxt_st.ch_prox     = CH_PROX;
			nxt_st.standoff    = STANDOFF;
			nxt_st.quick_rel   = QUICK_REL;
			nxt_st.movement    = MOVEMENT;
			nxt_st.filt_halt   = FILT_HALT;
			nxt_st.hys_mode    = HYS_MODE;
			nxt_st.hys_sign    = HYS_SIGN;
			nxt_st.hys_touch   = HYS_TOUCH;
			nxt_st.hys_prox    = HYS_PROX;
			nxt_st.hys_result  = HYS_RESULT;
			nxt_st.mag_touch   = MAG_TOUCH;
			nxt_st.mag_prox    = MAG_PROX;
			nxt_st.mag_pol     = mag_pol_in;
			nxt_st.mag_result  = mag_clamped;
			nxt_st.temp_trip   = TEMP_TRIP;
			nxt_st.temp_result = temp_value;
			// set wins over the read clear
			if ({CH_TOUCH, CH_PROX} != {st_ff.ch_touch, st_ff.ch_prox}) begin
				nxt_st.ev_cap = 1'b1;
			end
			if (!HYS_MODE && ({STANDOFF, QUICK_REL, MOVEMENT, FILT_HALT} !=
				{st_ff.standoff, st_ff.quick_rel, st_ff.movement, st_ff.filt_halt})) begin
				nxt_st.ev_body = 1'b1;
			end
			if ({MAG_TOUCH, MAG_PROX, mag_pol_in} !=
				{st_ff.mag_touch, st_ff.mag_prox, st_ff.mag_pol}) begin
				nxt_st.ev_mag = 1'b1;
			end
			if (HYS_MODE && ({HYS_SIGN, HYS_TOUCH, HYS_PROX} !=
				{st_ff.hys_sign, st_ff.hys_touch, st_ff.hys_prox})) begin
				nxt_st.ev_hys = 1'b1;
			end
		end
		if (!CE) begin
			nxt_st = st_ff;
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign RDATA      = st_ff.rdata;
	assign RVALID     = st_ff.rvalid;
	assign WR_IGNORED = st_ff.wr_ignored;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_rd(logic [7:0] a);
		CE && RD && (ADDR == a);
	endsequence

	sequence s_upd;
		CE && UPD;
	endsequence

	property p_chan_read;
		s_rd(`ADDR_CHAN_FLAGS) |=> RVALID && (RDATA[6:4] == $past(st_ff.ch_touch))
			&& (RDATA[2:0] == $past(st_ff.ch_prox)) && !RDATA[7] && !RDATA[3];
	endproperty
	a_chan_read: assert property (p_chan_read) else $error("channel flag read wrong");

	property p_chan_capture;
		s_upd |=> (st_ff.ch_prox == $past(CH_PROX)) && (st_ff.ch_touch == $past(CH_TOUCH));
	endproperty
	a_chan_capture: assert property (p_chan_capture) else $error("channel flags not taken");

	property p_shared_read;
		s_rd(`ADDR_BODY_HYS_FLAGS) |=> RDATA == ($past(st_ff.hys_mode) ?
			{$past(st_ff.hys_sign), $past(st_ff.hys_touch), $past(st_ff.hys_prox), 5'h00} :
			{3'h0, $past(st_ff.standoff), 1'b0, $past(st_ff.quick_rel),
			$past(st_ff.movement), $past(st_ff.filt_halt)});
	endproperty
	a_shared_read: assert property (p_shared_read) else $error("shared flag layout wrong");

	property p_hys_word;
		s_upd ##1 s_rd(`ADDR_HYS_RES_HI) |=> RDATA == $past(HYS_RESULT[15:8], 2);
	endproperty
	a_hys_word: assert property (p_hys_word) else $error("hysteresis high byte wrong");

	property p_mag_pol;
		s_upd |=> st_ff.mag_pol == ($past(MAG_SOUTH) ^ FLIP_CHIP);
	endproperty
	a_mag_pol: assert property (p_mag_pol) else $error("polarity encoding wrong");

	property p_mag_limit;
		s_upd |=> st_ff.mag_result <= `MAG_RESULT_MAX;
	endproperty
	a_mag_limit: assert property (p_mag_limit) else $error("magnetic result above limit");

	property p_temp_value;
		s_upd |=> st_ff.temp_result == (CALIBRATED ?
			16'($past(TEMP_RAW) + TEMP_OFFSET) : $past(TEMP_RAW));
	endproperty
	a_temp_value: assert property (p_temp_value) else $error("temperature value wrong");

	property p_cap_event_set;
		s_upd and ({CH_TOUCH, CH_PROX} != {st_ff.ch_touch, st_ff.ch_prox}) |=> st_ff.ev_cap;
	endproperty
	a_cap_event_set: assert property (p_cap_event_set) else $error("capacitive event lost");

	property p_event_clear;
		s_rd(`ADDR_GLOBAL_EVENTS) and !UPD |=> !st_ff.ev_hys && !st_ff.ev_cap;
	endproperty
	a_event_clear: assert property (p_event_clear) else $error("event not cleared on read");

	property p_write_ignored;
		CE && WR && !UPD && !RD |=> WR_IGNORED && $stable(st_ff.hys_result)
			&& $stable(st_ff.temp_result) && $stable(st_ff.ch_touch);
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write altered bank");

	property p_event_read;
		s_rd(`ADDR_GLOBAL_EVENTS) |=> RDATA == {3'h0, $past(st_ff.ev_hys), 1'b0,
			$past(st_ff.ev_mag), $past(st_ff.ev_body), $past(st_ff.ev_cap)};
	endproperty
	a_event_read: assert property (p_event_read) else $error("event byte wrong");

	property p_body_event_set;
		s_upd and (!HYS_MODE && ({STANDOFF, QUICK_REL, MOVEMENT, FILT_HALT} !=
			{st_ff.standoff, st_ff.quick_rel, st_ff.movement, st_ff.filt_halt}))
			|=> st_ff.ev_body;
	endproperty
	a_body_event_set: assert property (p_body_event_set) else $error("body event lost");

	property p_hys_event_set;
		s_upd and (HYS_MODE && ({HYS_SIGN, HYS_TOUCH, HYS_PROX} !=
			{st_ff.hys_sign, st_ff.hys_touch, st_ff.hys_prox})) |=> st_ff.ev_hys;
	endproperty
	a_hys_event_set: assert property (p_hys_event_set) else $error("hys event lost");

	property p_body_capture;
		s_upd |=> {st_ff.standoff, st_ff.quick_rel, st_ff.movement, st_ff.filt_halt}
			== $past({STANDOFF, QUICK_REL, MOVEMENT, FILT_HALT});
	endproperty
	a_body_capture: assert property (p_body_capture) else $error("body flags lost");

	property p_hys_capture;
		s_upd |=> (st_ff.hys_sign == $past(HYS_SIGN))
			&& (st_ff.hys_touch == $past(HYS_TOUCH)) && (st_ff.hys_prox == $past(HYS_PROX));
	endproperty
	a_hys_capture: assert property (p_hys_capture) else $error("hys flags lost");

	property p_mag_read;
		s_rd(`ADDR_MAG_FLAGS) |=> RDATA == {5'h00, $past(st_ff.mag_touch),
			$past(st_ff.mag_prox), $past(st_ff.mag_pol)};
	endproperty
	a_mag_read: assert property (p_mag_read) else $error("magnetic flag read wrong");

	property p_mag_capture;
		s_upd |=> (st_ff.mag_touch == $past(MAG_TOUCH))
			&& (st_ff.mag_prox == $past(MAG_PROX));
	endproperty
	a_mag_capture: assert property (p_mag_capture) else $error("magnetic flags lost");

	property p_temp_read;
		s_rd(`ADDR_TEMP_FLAGS) |=> RDATA == {$past(st_ff.temp_trip), 7'h00};
	endproperty
	a_temp_read: assert property (p_temp_read) else $error("temp flag wrong");

	property p_temp_word;
		s_rd(`ADDR_TEMP_RES_LO) |=> RDATA == $past(st_ff.temp_result[7:0]);
	endproperty
	a_temp_word: assert property (p_temp_word) else $error("temp low byte wrong");

	property p_answer_pulse;
		CE && !RD && !WR |=> !RVALID && !WR_IGNORED;
	endproperty
	a_answer_pulse: assert property (p_answer_pulse) else $error("answer pulse too long");

	property p_ce_hold;
		!CE |=> $stable(st_ff);
	endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("state moved while disabled");

endmodule

// ### sim/host_reader_model.sv
// Purpose: host side reader of the status bank
// Assumes: one-cycle answer on RVALID and WR_IGNORED
// Notes: address goes to its inverse once a request is taken
`timescale 1ns/100ps

module host_reader_model (
	input  wire logic       CLK,
	input  wire logic [7:0] RDATA,
	input  wire logic       RVALID,
	input  wire logic       WR_IGNORED,
	output logic [7:0]      ADDR,
	output logic            RD,
	output logic            WR
);
	initial begin
		ADDR = 8'h00;
		RD   = 1'b0;
		WR   = 1'b0;
	end

	// ----------------------------------------
	// register requests
	// ----------------------------------------
	task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int n;
		ok = 1'b0;
		d = 8'h00;
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		ADDR <= ~a;
		for (n = 0; n < 4 && !ok; n++) begin
			@(negedge CLK);
			if (RVALID === 1'b1) begin
				ok = 1'b1;
				d = RDATA;
			end
		end
		@(posedge CLK);
	endtask

	task automatic write_byte(input logic [7:0] a, output logic ok);
		ADDR <= a;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
		ADDR <= ~a;
		@(negedge CLK);
		ok = (WR_IGNORED === 1'b1);
		@(posedge CLK);
	endtask
endmodule

// ### sim/tb_sensor_ui_status_registers.sv
// Purpose: self-checking bench of the sensor status bank
// Assumes: host_reader_model issues all register requests
// Notes: second bank, flip-chip and calibrated, shares all inputs
`timescale 1ns/100ps

`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module tb_sensor_ui_status_registers;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic        CE = 1'b1;
	logic        UPD = 1'b0;
	logic [2:0]  CH_TOUCH = 3'h0, CH_PROX = 3'h0;
	logic        STANDOFF = 1'b0, QUICK_REL = 1'b0, MOVEMENT = 1'b0, FILT_HALT = 1'b0;
	logic        HYS_MODE = 1'b0, HYS_SIGN = 1'b0, HYS_TOUCH = 1'b0, HYS_PROX = 1'b0;
	logic        MAG_TOUCH = 1'b0, MAG_PROX = 1'b0, MAG_SOUTH = 1'b0, TEMP_TRIP = 1'b0;
	logic [15:0] HYS_RESULT = 16'h0000, MAG_RESULT = 16'h0000, TEMP_RAW = 16'h0000;
	logic [7:0]  ADDR, RDATA, RDATA_ALT;
	logic        RD, WR, RVALID, WR_IGNORED;
	int          bad_count = 0;
	int          check_count = 0;

	always #25 CLK = ~CLK;

	// ----------------------------------------
	// banks and host
	// ----------------------------------------
	sensor_ui_status_registers dut (
		.CLK(CLK), .RST(RST), .CE(CE), .UPD(UPD), .CH_TOUCH(CH_TOUCH), .CH_PROX(CH_PROX),
		.STANDOFF(STANDOFF), .QUICK_REL(QUICK_REL), .MOVEMENT(MOVEMENT), .FILT_HALT(FILT_HALT),
		.HYS_MODE(HYS_MODE), .HYS_SIGN(HYS_SIGN), .HYS_TOUCH(HYS_TOUCH), .HYS_PROX(HYS_PROX),
		.HYS_RESULT(HYS_RESULT), .MAG_TOUCH(MAG_TOUCH), .MAG_PROX(MAG_PROX),
		.MAG_SOUTH(MAG_SOUTH), .MAG_RESULT(MAG_RESULT), .TEMP_TRIP(TEMP_TRIP),
		.TEMP_RAW(TEMP_RAW), .ADDR(ADDR), .RD(RD), .WR(WR), .RDATA(RDATA), .RVALID(RVALID),
		.WR_IGNORED(WR_IGNORED)
	);

	sensor_ui_status_registers #(.FLIP_CHIP(1'b1), .CALIBRATED(1'b1), .TEMP_OFFSET(16'h0028))
	dut_alt (
		.CLK(CLK), .RST(RST), .CE(CE), .UPD(UPD), .CH_TOUCH(CH_TOUCH), .CH_PROX(CH_PROX),
		.STANDOFF(STANDOFF), .QUICK_REL(QUICK_REL), .MOVEMENT(MOVEMENT), .FILT_HALT(FILT_HALT),
		.HYS_MODE(HYS_MODE), .HYS_SIGN(HYS_SIGN), .HYS_TOUCH(HYS_TOUCH), .HYS_PROX(HYS_PROX),
		.HYS_RESULT(HYS_RESULT), .MAG_TOUCH(MAG_TOUCH), .MAG_PROX(MAG_PROX),
		.MAG_SOUTH(MAG_SOUTH), .MAG_RESULT(MAG_RESULT), .TEMP_TRIP(TEMP_TRIP),
		.TEMP_RAW(TEMP_RAW), .ADDR(ADDR), .RD(RD), .WR(WR), .RDATA(RDATA_ALT), .RVALID(),
		.WR_IGNORED()
	);

	host_reader_model host (.CLK(CLK), .RDATA(RDATA), .RVALID(RVALID),
		.WR_IGNORED(WR_IGNORED), .ADDR(ADDR), .RD(RD), .WR(WR));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic upd_engine();
		UPD <= 1'b1;
		@(posedge CLK);
		UPD <= 1'b0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] ea);
		logic [7:0] d;
		logic       ok;
		host.read_byte(a, d, ok);
		if (!ok) begin
			bad_count++;
			give_verdict();
		end
		`CHK($sformatf("reg %h", a), e, d)
		`CHK($sformatf("alt reg %h", a), ea, RDATA_ALT)
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic scen_reset();
		int a;
		for (a = 8'h11; a <= 8'h1b; a++) begin
			rc(a[7:0], 8'h00, 8'h00);
		end
	endtask

	task automatic scen_channels();
		CH_TOUCH <= 3'b101;
		CH_PROX <= 3'b010;
		upd_engine();
		rc(8'h12, 8'h52, 8'h52);
		rc(8'h11, 8'h01, 8'h05);
		rc(8'h11, 8'h00, 8'h00);
	endtask

	task automatic scen_body();
		{STANDOFF, QUICK_REL, MOVEMENT, FILT_HALT} <= 4'b1011;
		upd_engine();
		rc(8'h13, 8'h13, 8'h13);
		rc(8'h11, 8'h02, 8'h02);
		{STANDOFF, QUICK_REL, MOVEMENT, FILT_HALT} <= 4'b0100;
		upd_engine();
		rc(8'h13, 8'h04, 8'h04);
		rc(8'h11, 8'h02, 8'h02);
	endtask

	task automatic scen_hys();
		{HYS_MODE, HYS_SIGN, HYS_TOUCH, HYS_PROX} <= 4'b1101;
		HYS_RESULT <= 16'hbeef;
		upd_engine();
		rc(8'h15, 8'hbe, 8'hbe);
		rc(8'h13, 8'ha0, 8'ha0);
		rc(8'h14, 8'hef, 8'hef);
		rc(8'h11, 8'h10, 8'h10);
		{HYS_SIGN, HYS_TOUCH, HYS_PROX} <= 3'b010;
		upd_engine();
		rc(8'h13, 8'h40, 8'h40);
		rc(8'h11, 8'h10, 8'h10);
	endtask

	task automatic scen_mag_temp();
		{MAG_TOUCH, MAG_PROX, MAG_SOUTH} <= 3'b101;
		MAG_RESULT <= 16'h1f41;
		TEMP_TRIP <= 1'b1;
		TEMP_RAW <= 16'hfff0;
		upd_engine();
		rc(8'h16, 8'h05, 8'h04);
		rc(8'h17, 8'h40, 8'h40);
		rc(8'h18, 8'h1f, 8'h1f);
		rc(8'h19, 8'h80, 8'h80);
		rc(8'h1a, 8'hf0, 8'h18);
		rc(8'h1b, 8'hff, 8'h00);
		rc(8'h11, 8'h04, 8'h04);
		{MAG_TOUCH, MAG_PROX, MAG_SOUTH} <= 3'b010;
		MAG_RESULT <= 16'h0abc;
		upd_engine();
		rc(8'h16, 8'h02, 8'h03);
		rc(8'h17, 8'hbc, 8'hbc);
		rc(8'h18, 8'h0a, 8'h0a);
		rc(8'h11, 8'h04, 8'h04);
	endtask

	task automatic scen_write();
		logic ok;
		host.write_byte(8'h12, ok);
		`CHK("write answer", 1'b1, ok)
		rc(8'h12, 8'h52, 8'h52);
		host.write_byte(8'h1a, ok);
		`CHK("write answer", 1'b1, ok)
		rc(8'h1a, 8'hf0, 8'h18);
		rc(8'h30, 8'h00, 8'h00);
		HYS_MODE <= 1'b0;
		upd_engine();
		rc(8'h13, 8'h04, 8'h04);
	endtask

	task automatic scen_hold_reset();
		CE <= 1'b0;
		CH_TOUCH <= 3'b010;
		upd_engine();
		CE <= 1'b1;
		rc(8'h12, 8'h52, 8'h52);
		rc(8'h11, 8'h00, 8'h00);
		RST <= 1'b1;
		@(posedge CLK);
		RST <= 1'b0;
		rc(8'h12, 8'h00, 8'h00);
		rc(8'h1a, 8'h00, 8'h00);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge CLK);
		RST <= 1'b0;
		scen_reset();
		scen_channels();
		scen_body();
		scen_hys();
		scen_mag_temp();
		scen_write();
		scen_hold_reset();
		give_verdict();
	end
endmodule
